// ### rtl/ecctcm_coupled_ram_wrapper.sv
// coupled data ram wrapper: two byte-interleaved ecc banks behind the core memory port
// Functional notes
// RL1: the wrapper answers every data ram read and write of the core's second coupled memory port.
// RL2: every access carries a 64-bit data word and its 8-bit ecc code.
// RL3: a read returns the stored ecc code unchanged and leaves checking to the core.
// RL4: a write stores the core's ecc code beside the written data.
// RL5: error events from the core raise a single-bit or a multibit error interrupt.
// RL6: the addresses behind single-bit and multibit errors are captured separately.
// RL7: the address of each access is parity checked.
// RL8: bank select and ecc select are each decoded twice and compared.
// RL9: the ram is two 36-bit byte-interleaved banks with their own control signals.
// RL10: a hardware sequence initialises both banks together with their ecc bits.
// RL11: only byte-granular or wider writes are supported, never single bits.
// RL12: the core must enable its event signalling and ecc checking before errors are seen.
// RL13: initialisation starts only with the global enable set and the ram selected by select bit 0.
// RL14: initialised words carry check bits consistent with the ecc scheme.
// RL15: the core corrects and flags single-bit errors and only flags multibit errors.
// RL16: a captured error address holds until software clears it.
`timescale 1ns/10ps
`default_nettype none
module ecctcm_coupled_ram_wrapper
  import ecctcm_pkg::*;
#(
  parameter int ADDR_W = ECCTCM_ADDR_W,
  parameter logic [ECCTCM_ECC_W-1:0] INIT_ECC = ECCTCM_INIT_ECC
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic req_in,
  input wire logic wr_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic addr_par_in,
  input wire logic [ECCTCM_LANES-1:0] byte_en_in,
  input wire logic [ECCTCM_DATA_W-1:0] wdata_in,
  input wire logic [ECCTCM_ECC_W-1:0] wecc_in,
  input wire logic evt_sbe_in,
  input wire logic evt_mbe_in,
  input wire logic sbe_clr_in,
  input wire logic mbe_clr_in,
  input wire logic mem_init_global_enable_in,
  input wire logic [ECCTCM_SEL_W-1:0] mem_init_select_in,
  output logic ready_out,
  output logic rvalid_out,
  output logic [ECCTCM_DATA_W-1:0] rdata_out,
  output logic [ECCTCM_ECC_W-1:0] recc_out,
  output logic addr_par_err_out,
  output logic decode_err_out,
  output logic sbe_irq_out,
  output logic mbe_irq_out,
  output logic [ADDR_W-1:0] sbe_addr_out,
  output logic [ADDR_W-1:0] mbe_addr_out,
  output logic init_busy_out,
  output logic init_done_out
);

  localparam int HALF = ECCTCM_LANES / 2;
  localparam int ECC_HALF = ECCTCM_ECC_W / 2;
  localparam logic [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}};
  localparam logic [ADDR_W-1:0] ADDR_RST = ADDR_W'(ECCTCM_ADDR_RST);

  // bank b holds byte lanes b, b+2, b+4, b+6 and ecc nibble b
  function automatic logic [1:0] bank_sel(input logic req, input logic [ECCTCM_LANES-1:0] be);
    logic [1:0] cs;
    cs = 2'b00;
    for (int i = 0; i < HALF; i++) begin
      cs[0] = cs[0] | (req & be[2*i]);
      cs[1] = cs[1] | (req & be[2*i+1]);
    end
    return cs;
  endfunction : bank_sel

  function automatic logic [1:0] ecc_sel(input logic req, input logic wr, input logic [ECCTCM_LANES-1:0] be);
    return {2{req & wr & (|be)}};
  endfunction : ecc_sel

  logic [ECCTCM_BANK_W-1:0] bank0_mem [2**ADDR_W];
  logic [ECCTCM_BANK_W-1:0] bank1_mem [2**ADDR_W];

  ecctcm_state_t state_r, state_nxt;
  logic [ADDR_W-1:0] init_addr_r, init_addr_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic rvalid_r, rvalid_nxt;
  logic busy_r, busy_nxt;
  logic [ECCTCM_DATA_W-1:0] rdata_r, rdata_nxt;
  logic [ECCTCM_ECC_W-1:0] recc_r, recc_nxt;
  logic [ADDR_W-1:0] last_rd_r, last_rd_nxt;
  logic par_err_r, par_err_nxt;
  logic dec_err_r, dec_err_nxt;
  logic sbe_r, sbe_nxt, mbe_r, mbe_nxt;
  logic [ADDR_W-1:0] sbe_addr_r, sbe_addr_nxt, mbe_addr_r, mbe_addr_nxt;

  logic take, par_ok;
  logic [1:0] cs_a, cs_b, es_a, es_b;
  logic [1:0] bank_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [ECCTCM_LANES-1:0] lane_we;
  logic [ECCTCM_DATA_W-1:0] mem_wdata;
  logic [ECCTCM_ECC_W-1:0] mem_wecc;

  always_comb begin
    take = req_in & ready_r; // RL1
    par_ok = ~(^{addr_in, addr_par_in}); // RL7
    cs_a = bank_sel(take, byte_en_in); // RL8
    cs_b = bank_sel(take, byte_en_in);
    es_a = ecc_sel(take, wr_in, byte_en_in);
    es_b = ecc_sel(take, wr_in, byte_en_in);
    // a write with a corrupt address or a decode mismatch is dropped rather than landing anywhere
    if (state_r == ECCTCM_INIT) begin
      bank_we = 2'b11; // RL10
      mem_addr = init_addr_r;
      lane_we = {ECCTCM_LANES{1'b1}};
      mem_wdata = ECCTCM_INIT_DATA;
      mem_wecc = INIT_ECC; // RL14
    end else begin
      bank_we = (wr_in & par_ok & (cs_a == cs_b) & (es_a == es_b)) ? cs_a : 2'b00; // RL9
      mem_addr = addr_in;
      lane_we = byte_en_in; // RL11
      mem_wdata = wdata_in;
      mem_wecc = wecc_in;
    end
  end

  // ram arrays; ecc nibble written with any lane of its bank
  always_ff @(posedge core_clk_in) begin
    for (int i = 0; i < HALF; i++) begin
      if (bank_we[0] && lane_we[2*i]) begin
        bank0_mem[mem_addr][8*i +: 8] <= mem_wdata[16*i +: 8]; // RL9
      end
      if (bank_we[1] && lane_we[2*i+1]) begin
        bank1_mem[mem_addr][8*i +: 8] <= mem_wdata[16*i+8 +: 8];
      end
    end
    if (bank_we[0]) begin
      bank0_mem[mem_addr][ECCTCM_BANK_W-1 -: ECC_HALF] <= mem_wecc[ECC_HALF-1:0]; // RL4
    end
    if (bank_we[1]) begin
      bank1_mem[mem_addr][ECCTCM_BANK_W-1 -: ECC_HALF] <= mem_wecc[ECCTCM_ECC_W-1 -: ECC_HALF];
    end
  end

  // read word captured at the taking edge so the port outputs come from flops and survive later writes
  always_comb begin
    rdata_nxt = rdata_r;
    recc_nxt = recc_r;
    if (take && !wr_in) begin
      for (int i = 0; i < HALF; i++) begin
        rdata_nxt[16*i +: 8] = bank0_mem[addr_in][8*i +: 8]; // RL2
        rdata_nxt[16*i+8 +: 8] = bank1_mem[addr_in][8*i +: 8];
      end
      recc_nxt = {bank1_mem[addr_in][ECCTCM_BANK_W-1 -: ECC_HALF],
                  bank0_mem[addr_in][ECCTCM_BANK_W-1 -: ECC_HALF]}; // RL3
    end
  end

  always_comb begin
    state_nxt = state_r;
    init_addr_nxt = init_addr_r;
    done_nxt = done_r;
    unique case (state_r)
      ECCTCM_IDLE: begin
        if (mem_init_global_enable_in && mem_init_select_in[ECCTCM_SEL_RAM_BIT]) begin
          state_nxt = ECCTCM_INIT; // RL13
          init_addr_nxt = ADDR_RST;
          done_nxt = 1'b0;
        end else if (!mem_init_global_enable_in) begin
          state_nxt = ECCTCM_RUN;
        end
      end
      ECCTCM_INIT: begin
        init_addr_nxt = init_addr_r + 1'b1;
        if (init_addr_r == LAST_ADDR) begin
          state_nxt = ECCTCM_RUN;
          done_nxt = 1'b1;
        end
      end
      ECCTCM_RUN: begin
        // a fresh enable pulse can re-run the sequence once the port is idle
        if (mem_init_global_enable_in && mem_init_select_in[ECCTCM_SEL_RAM_BIT] && !req_in) begin
          state_nxt = ECCTCM_INIT; // RL13
          init_addr_nxt = ADDR_RST;
          done_nxt = 1'b0;
        end
      end
      default: state_nxt = ECCTCM_IDLE;
    endcase
    ready_nxt = (state_nxt == ECCTCM_RUN);
    busy_nxt = (state_nxt == ECCTCM_INIT); // RL10
  end

  always_comb begin
    rvalid_nxt = take & ~wr_in; // RL1
    last_rd_nxt = (take && !wr_in) ? addr_in : last_rd_r;
    par_err_nxt = take & ~par_ok; // RL7
    dec_err_nxt = (cs_a != cs_b) | (es_a != es_b); // RL8
    // event sets win over a clear in the same cycle; address is held while flag stands and no clear is applied
    sbe_nxt = evt_sbe_in | (sbe_r & ~sbe_clr_in); // RL5
    mbe_nxt = evt_mbe_in | (mbe_r & ~mbe_clr_in);
    sbe_addr_nxt = (evt_sbe_in && (!sbe_r || sbe_clr_in)) ? last_rd_r : sbe_addr_r; // RL6 RL16
    mbe_addr_nxt = (evt_mbe_in && (!mbe_r || mbe_clr_in)) ? last_rd_r : mbe_addr_r; // RL6 RL16
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= ECCTCM_IDLE;
      init_addr_r <= ADDR_RST;
      ready_r <= 1'b0;
      done_r <= 1'b0;
      rvalid_r <= 1'b0;
      busy_r <= 1'b0;
      rdata_r <= ECCTCM_INIT_DATA;
      recc_r <= INIT_ECC;
      last_rd_r <= ADDR_RST;
      par_err_r <= 1'b0;
      dec_err_r <= 1'b0;
      sbe_r <= 1'b0;
      mbe_r <= 1'b0;
      sbe_addr_r <= ADDR_RST;
      mbe_addr_r <= ADDR_RST;
    end else begin
      state_r <= state_nxt;
      init_addr_r <= init_addr_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      rvalid_r <= rvalid_nxt;
      busy_r <= busy_nxt;
      rdata_r <= rdata_nxt;
      recc_r <= recc_nxt;
      last_rd_r <= last_rd_nxt;
      par_err_r <= par_err_nxt;
      dec_err_r <= dec_err_nxt;
      sbe_r <= sbe_nxt;
      mbe_r <= mbe_nxt;
      sbe_addr_r <= sbe_addr_nxt;
      mbe_addr_r <= mbe_addr_nxt;
    end
  end

  always_comb begin
    ready_out = ready_r;
    rvalid_out = rvalid_r;
    rdata_out = rdata_r;
    recc_out = recc_r;
    addr_par_err_out = par_err_r;
    decode_err_out = dec_err_r;
    sbe_irq_out = sbe_r;
    mbe_irq_out = mbe_r;
    sbe_addr_out = sbe_addr_r;
    mbe_addr_out = mbe_addr_r;
    init_busy_out = busy_r;
    init_done_out = done_r;
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_read_answer: assert property (req_in && ready_out && !wr_in |=> rvalid_out) // RL1
    else $error("read not answered next cycle");
  a_no_spurious_rd: assert property (!(req_in && ready_out && !wr_in) |=> !rvalid_out) // RL1
    else $error("read answer without request");
  a_ecc_roundtrip: assert property (req_in && ready_out && wr_in && byte_en_in == 8'hFF && !(^{addr_in, addr_par_in})
    ##1 req_in && ready_out && !wr_in && $past(addr_in) == addr_in
    |=> recc_out == $past(wecc_in, 2) && rdata_out == $past(wdata_in, 2)) // RL2 RL3 RL4
    else $error("stored ecc or data not returned");
  a_sbe_raise: assert property (evt_sbe_in |=> sbe_irq_out) // RL5
    else $error("single-bit event lost");
  a_mbe_raise: assert property (evt_mbe_in |=> mbe_irq_out) // RL5
    else $error("multibit event lost");
  a_sbe_hold: assert property (sbe_irq_out && !sbe_clr_in |=> $stable(sbe_addr_out)) // RL16
    else $error("captured single-bit address overwritten");
  a_mbe_capture: assert property (evt_mbe_in && !mbe_irq_out ##1 1 |-> mbe_addr_out == $past(last_rd_r)) // RL6
    else $error("multibit address not captured");
  a_par_flag: assert property (req_in && ready_out && (^{addr_in, addr_par_in}) |=> addr_par_err_out) // RL7
    else $error("address parity error not flagged");
  a_dec_agree: assert property (!decode_err_out) // RL8
    else $error("redundant decoders disagree");
  a_init_gate: assert property (init_busy_out && !$past(init_busy_out) |->
    $past(mem_init_global_enable_in) && $past(mem_init_select_in[ECCTCM_SEL_RAM_BIT])) // RL13
    else $error("init began without enable");
  a_init_blocks: assert property (init_busy_out |-> !ready_out && bank_we == 2'b11) // RL10 RL9
    else $error("port open or bank idle during init");

  c_init_done: cover property (init_busy_out ##1 init_done_out);
  c_wr_then_rd: cover property (req_in && ready_out && wr_in ##1 req_in && ready_out && !wr_in);
  c_sbe_clear: cover property (sbe_irq_out && sbe_clr_in && evt_sbe_in);
  c_par_err: cover property (addr_par_err_out);

endmodule : ecctcm_coupled_ram_wrapper
`default_nettype wire

// ### inc/ecctcm_pkg.sv
// shared constants for the coupled data ram wrapper
package ecctcm_pkg;
  localparam int ECCTCM_DATA_W = 64;
  localparam int ECCTCM_ECC_W = 8;
  localparam int ECCTCM_BANK_W = 36;
  localparam int ECCTCM_LANES = 8;
  localparam int ECCTCM_ADDR_W = 12;
  localparam int ECCTCM_SEL_W = 9;
  localparam int ECCTCM_SEL_RAM_BIT = 0;
  localparam logic [ECCTCM_DATA_W-1:0] ECCTCM_INIT_DATA = 64'h0000_0000_0000_0000;
  localparam logic [ECCTCM_ECC_W-1:0] ECCTCM_INIT_ECC = 8'h00;
  localparam logic [ECCTCM_ADDR_W-1:0] ECCTCM_ADDR_RST = 12'h000;
  typedef enum logic [2:0] {
    ECCTCM_IDLE = 3'b001,
    ECCTCM_INIT = 3'b010,
    ECCTCM_RUN = 3'b100
  } ecctcm_state_t;
endpackage : ecctcm_pkg

// ### verification/ecctcm_core_model.sv
// core-side model: checks the returned ecc code and reports errors on the event bus
`timescale 1ns/10ps
`default_nettype none
module ecctcm_core_model
  import ecctcm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic chk_en_in,
  input wire logic rvalid_in,
  input wire logic [ECCTCM_DATA_W-1:0] rdata_in,
  input wire logic [ECCTCM_ECC_W-1:0] recc_in,
  output logic evt_sbe_out,
  output logic evt_mbe_out
);
  logic [ECCTCM_ECC_W-1:0] diff;
  // byte fold stands in for the core's real code; only the syndrome weight matters here
  always @(negedge core_clk_in) begin
    diff = recc_in;
    for (int i = 0; i < ECCTCM_LANES; i++) begin
      diff ^= rdata_in[8*i+:8];
    end
    evt_sbe_out <= chk_en_in && rvalid_in === 1'b1 && $countones(diff) == 1;
    evt_mbe_out <= chk_en_in && rvalid_in === 1'b1 && $countones(diff) > 1;
  end
endmodule : ecctcm_core_model
`default_nettype wire

// ### verification/tb_ecc_tcm_ram_wrapper.sv
// self-checking bench for the coupled data ram wrapper
`timescale 1ns/10ps
`default_nettype none
module tb_ecc_tcm_ram_wrapper;
  import ecctcm_pkg::*;
  localparam int AW = 4;
  logic core_clk_in = 1'b0, nrst_in = 1'b0, req = 1'b0, wr = 1'b0, par = 1'b0, chk_en = 1'b0;
  logic sclr = 1'b0, mclr = 1'b0, gen = 1'b0, sbe, mbe, ready, rvalid, perr, derr, sirq, mirq, busy, done;
  logic [AW-1:0] addr = '0, saddr, maddr;
  logic [7:0] be = 8'h00, we = 8'h00, recc;
  logic [8:0] sel = 9'h000;
  logic [63:0] wd = '0, rdata;
  logic [63:0] mem [16];
  logic [7:0] ecm [16];
  logic [71:0] q [$];
  logic [31:0] rs = 32'd71772;
  logic [63:0] d;
  int err_count = 0, checks = 0;
  always #5 core_clk_in = ~core_clk_in;
  ecctcm_coupled_ram_wrapper #(.ADDR_W(AW)) dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .req_in(req),
    .wr_in(wr), .addr_in(addr), .addr_par_in(par), .byte_en_in(be), .wdata_in(wd), .wecc_in(we),
    .evt_sbe_in(sbe), .evt_mbe_in(mbe), .sbe_clr_in(sclr), .mbe_clr_in(mclr), .mem_init_global_enable_in(gen),
    .mem_init_select_in(sel), .ready_out(ready), .rvalid_out(rvalid), .rdata_out(rdata), .recc_out(recc),
    .addr_par_err_out(perr), .decode_err_out(derr), .sbe_irq_out(sirq), .mbe_irq_out(mirq),
    .sbe_addr_out(saddr), .mbe_addr_out(maddr), .init_busy_out(busy), .init_done_out(done));
  ecctcm_core_model core (.core_clk_in(core_clk_in), .chk_en_in(chk_en), .rvalid_in(rvalid), .rdata_in(rdata),
    .recc_in(recc), .evt_sbe_out(sbe), .evt_mbe_out(mbe));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  function automatic logic [7:0] code(input logic [63:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      c ^= v[8*i+:8];
    end
    return c;
  endfunction : code
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // the mirror follows the lane-to-bank pairing, so a write moves only the ecc nibbles of the banks that its lanes touch
  task automatic acc(input logic w, input logic [AW-1:0] a, input logic [7:0] b, input logic [63:0] v,
    input logic [7:0] e, input logic bad);
    @(negedge core_clk_in);
    req = 1'b1;
    wr = w;
    addr = a;
    par = ^a ^ bad;
    be = b;
    wd = v;
    we = e;
    if (!w) q.push_back({mem[a], ecm[a]});
    else if (!bad) begin
      for (int i = 0; i < 8; i++) begin
        if (b[i]) mem[a][8*i+:8] = v[8*i+:8];
      end
      if (|(b & 8'h55)) ecm[a][3:0] = e[3:0];
      if (|(b & 8'hAA)) ecm[a][7:4] = e[7:4];
    end
    @(posedge core_clk_in);
  endtask : acc
  task automatic idle(input int c);
    repeat (c) @(negedge core_clk_in) req = 1'b0;
  endtask : idle
  // bounded wait for the end of an init sequence; the caller compares done afterwards
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge core_clk_in);
      n++;
    end
  endtask : wait_done
  always @(negedge core_clk_in) begin
    if (rvalid === 1'b1) begin
      if (q.size() == 0) chk(72'h1, 72'h0);
      else chk({rdata, recc}, q.pop_front());
    end
  end
  initial begin
    repeat (2) @(negedge core_clk_in);
    nrst_in = 1'b1;
    idle(2);
    chk(72'(ready), 72'h1);
    for (int a = 0; a < 16; a++) begin
      d = {rnd(), rnd()};
      acc(1'b1, AW'(a), 8'hFF, d, code(d), 1'b0);
    end
    for (int a = 0; a < 16; a++) acc(1'b0, AW'(a), 8'h00, '0, 8'h00, 1'b0);
    // one lane per write walks every lane over both banks
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, AW'(k), 8'h01 << k, {rnd(), rnd()}, 8'(rnd()), 1'b0);
      acc(1'b0, AW'(k), 8'h00, '0, 8'h00, 1'b0);
    end
    acc(1'b1, 4'h2, 8'hFF, {rnd(), rnd()}, 8'h5A, 1'b1);
    idle(1);
    chk(72'(perr), 72'h1);
    acc(1'b0, 4'h2, 8'h00, '0, 8'h00, 1'b0);
    idle(4);
    chk({sirq, mirq}, 72'h0);
    chk_en = 1'b1;
    for (int a = 5; a < 8; a++) begin
      d = {rnd(), rnd()};
      acc(1'b1, AW'(a), 8'hFF, d, code(d) ^ (a == 6 ? 8'h03 : 8'h01), 1'b0);
    end
    acc(1'b0, 4'h5, 8'h00, '0, 8'h00, 1'b0);
    idle(4);
    chk({sirq, saddr}, {1'b1, 4'h5});
    acc(1'b0, 4'h6, 8'h00, '0, 8'h00, 1'b0);
    acc(1'b0, 4'h7, 8'h00, '0, 8'h00, 1'b0);
    idle(4);
    chk({mirq, maddr, saddr}, {1'b1, 4'h6, 4'h5});
    @(negedge core_clk_in) {sclr, mclr} = 2'b11;
    @(negedge core_clk_in) {sclr, mclr} = 2'b00;
    idle(2);
    chk({sirq, mirq}, 72'h0);
    sel = {8'(rnd()), 1'b0};
    gen = 1'b1;
    idle(3);
    chk(72'(busy), 72'h0);
    sel[0] = 1'b1;
    idle(1);
    chk({busy, ready}, 72'h2);
    gen = 1'b0;
    wait_done();
    chk(72'(done), 72'h1);
    if (done === 1'b1) begin
      chk(72'(ready), 72'h1);
      for (int a = 0; a < 16; a++) begin
        mem[a] = ECCTCM_INIT_DATA;
        ecm[a] = ECCTCM_INIT_ECC;
        acc(1'b0, AW'(a), 8'h00, '0, 8'h00, 1'b0);
      end
      idle(6);
      chk({sirq, mirq, derr}, 72'h0);
      chk(72'(q.size()), 72'h0);
      // second reset with the enable held: the sequence must start straight out of reset
      nrst_in = 1'b0;
      gen = 1'b1;
      idle(2);
      nrst_in = 1'b1;
      idle(1);
      chk({busy, ready}, 72'h2);
      gen = 1'b0;
      wait_done();
      chk({done, ready}, 72'h3);
    end
    conclude();
  end
endmodule : tb_ecc_tcm_ram_wrapper
`default_nettype wire
